// ===== include/sstp_pkg.sv
`default_nettype none
package sstp_pkg;
  // output instruction that carries serial transmit and reader control
  localparam logic [7:0] SERIAL_OUTPUT_CODE = 8'h67;
  // data bus bit positions used by the serial output instruction
  localparam int TX_DATA_BIT = 0;
  localparam int READER_START_BIT = 7;
  localparam int READER_STOP_BIT = 6;
  // line levels
  localparam logic LINE_MARK = 1'b1;
  localparam logic LINE_SPACE = 1'b0;
  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] TXCMD_OFFSET = 8'h08;
  // control register fields
  localparam int CTRL_PATCH_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // status register fields
  localparam int STAT_TX_LEVEL_BIT = 0;
  localparam int STAT_READER_RUN_BIT = 1;
  localparam int STAT_RX_LEVEL_BIT = 2;
  localparam int STAT_FLAG_LEVEL_BIT = 3;
  localparam int STAT_SELECT_BIT = 4;
  localparam int STAT_PATCH_ACTIVE_BIT = 5;
  // default synchroniser depth
  localparam int SYNC_STAGES_DEFAULT = 2;
endpackage
`default_nettype wire

// ===== src/sstp_port.sv
// Summary of operation
// - receive line reaches active-low receive flag
// - instruction 67 latches bus bit 0 out
// - characters framed by start and stop bits
// - select low disconnects receive line from flag
// - flag drive is wire-OR capable open drain
// - same instruction bits 7,6 control reader
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module sstp_port
  import sstp_pkg::*;
#(
  parameter int SYNC_STAGES = sstp_pkg::SYNC_STAGES_DEFAULT
)
(
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor output instruction, same clock
  input wire logic io_out_strobe,
  input wire logic [7:0] io_code,
  input wire logic [7:0] data_bus,
  // terminal side pins
  input wire logic rx_line,
  output logic tx_line,
  output logic reader_run,
  input wire logic port_select,
  // shared active-low flag pin, open drain
  input wire logic receive_flag_input_low_i,
  output logic receive_flag_input_low_o,
  output logic receive_flag_input_low_oe
);
  import sstp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check
  generate
    if (SYNC_STAGES < 2)
    begin : g_bad_sync
      $error("SYNC_STAGES must be at least 2");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [SYNC_STAGES-1:0] rx_sync_ff;
  logic [SYNC_STAGES-1:0] sel_sync_ff;
  logic [SYNC_STAGES-1:0] flag_sync_ff;
  logic rx_s;
  logic sel_s;
  logic flag_s;

  // shift chains, idle levels at reset
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_sync_ff <= {SYNC_STAGES{LINE_MARK}};
      sel_sync_ff <= '0;
      flag_sync_ff <= '1;
    end
    else
    begin
      rx_sync_ff <= {rx_sync_ff[SYNC_STAGES-2:0], rx_line};
      sel_sync_ff <= {sel_sync_ff[SYNC_STAGES-2:0], port_select};
      flag_sync_ff <= {flag_sync_ff[SYNC_STAGES-2:0], receive_flag_input_low_i};
    end
  end

  assign rx_s = rx_sync_ff[SYNC_STAGES-1];
  assign sel_s = sel_sync_ff[SYNC_STAGES-1];
  assign flag_s = flag_sync_ff[SYNC_STAGES-1];

  ////////////////////////////////////////////////////////////////////////////
  // apb slave
  logic [31:0] ctrl_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic tx_line_ff;
  logic reader_run_ff;
  logic flag_oe_ff;
  logic flag_o_ff;
  logic apb_done;
  logic addr_ok;
  logic txcmd_wr;
  logic io_serial_out;
  logic [7:0] nxt_cmd;
  logic cmd_valid;
  logic [31:0] status_word;
  logic patch_active;

  // access ends on the second access cycle
  assign apb_done = psel && penable && pready_ff;
  assign addr_ok = (paddr == CTRL_OFFSET) || (paddr == STATUS_OFFSET)
                   || (paddr == TXCMD_OFFSET);
  assign txcmd_wr = apb_done && pwrite && (paddr == TXCMD_OFFSET);
  assign patch_active = sel_s && ctrl_ff[CTRL_PATCH_EN_BIT];

  // status readback of block state
  always_comb
  begin
    status_word = '0;
    status_word[STAT_TX_LEVEL_BIT] = tx_line_ff;
    status_word[STAT_READER_RUN_BIT] = reader_run_ff;
    status_word[STAT_RX_LEVEL_BIT] = rx_s;
    status_word[STAT_FLAG_LEVEL_BIT] = flag_s;
    status_word[STAT_SELECT_BIT] = sel_s;
    status_word[STAT_PATCH_ACTIVE_BIT] = patch_active;
  end

  // ready, error and read data
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end
    else
    begin
      pready_ff <= psel && penable && !pready_ff;
      pslverr_ff <= psel && penable && !pready_ff && !addr_ok;
      if (psel && penable && !pready_ff && !pwrite)
      begin
        case (paddr)
          CTRL_OFFSET: prdata_ff <= ctrl_ff;
          STATUS_OFFSET: prdata_ff <= status_word;
          default: prdata_ff <= '0;
        endcase
      end
      else if (apb_done)
      begin
        prdata_ff <= '0;
      end
    end
  end

  // control register write
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff <= CTRL_RESET;
    end
    else if (apb_done && pwrite && (paddr == CTRL_OFFSET))
    begin
      ctrl_ff <= {31'h0000_0000, pwdata[CTRL_PATCH_EN_BIT]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output instruction decode; processor wins over apb
  assign io_serial_out = io_out_strobe && (io_code == SERIAL_OUTPUT_CODE);
  assign cmd_valid = io_serial_out || txcmd_wr;
  assign nxt_cmd = io_serial_out ? data_bus : pwdata[7:0];

  // transmit flip-flop holds level until next output
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_line_ff <= LINE_MARK;
    end
    else if (cmd_valid)
    begin
      tx_line_ff <= nxt_cmd[TX_DATA_BIT];
    end
  end

  // paper tape reader start and stop, stop wins
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reader_run_ff <= 1'b0;
    end
    else if (cmd_valid)
    begin
      if (nxt_cmd[READER_STOP_BIT])
      begin
        reader_run_ff <= 1'b0;
      end
      else if (nxt_cmd[READER_START_BIT])
      begin
        reader_run_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive line onto shared flag, pulls low on space only
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_oe_ff <= 1'b0;
      flag_o_ff <= 1'b0;
    end
    else
    begin
      flag_oe_ff <= patch_active && (rx_s == LINE_SPACE);
      flag_o_ff <= 1'b0;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign tx_line = tx_line_ff;
  assign reader_run = reader_run_ff;
  assign receive_flag_input_low_o = flag_o_ff;
  assign receive_flag_input_low_oe = flag_oe_ff;

endmodule // sstp_port
`default_nettype wire

// ===== verif/sstp_chk_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module sstp_chk
  import sstp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic io_out_strobe,
  input wire logic [7:0] io_code,
  input wire logic [7:0] data_bus,
  input wire logic rx_line,
  input wire logic tx_line,
  input wire logic reader_run,
  input wire logic port_select,
  input wire logic pready,
  input wire logic receive_flag_input_low_o,
  input wire logic receive_flag_input_low_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic hit;
  // serial output instruction seen
  assign hit = io_out_strobe && io_code == SERIAL_OUTPUT_CODE;
  property p_tx; hit |=> tx_line == $past(data_bus[0]); endproperty
  a_tx: assert property (p_tx) else $error("tx bit");
  property p_hold; !hit && !pready |=> $stable(tx_line); endproperty
  a_hold: assert property (p_hold) else $error("tx moved");
  property p_flag; receive_flag_input_low_oe |-> !$past(rx_line, 3); endproperty
  a_flag: assert property (p_flag) else $error("flag");
  property p_sel; receive_flag_input_low_oe |-> $past(port_select, 3); endproperty
  a_sel: assert property (p_sel) else $error("select");
  property p_od; receive_flag_input_low_o == LINE_SPACE; endproperty
  a_od: assert property (p_od) else $error("open drain");
  property p_rd; hit && (data_bus[7] || data_bus[6]) |=> reader_run == !$past(data_bus[6]);
  endproperty
  a_rd: assert property (p_rd) else $error("reader");
  property p_idle; $rose(rst_n) |-> tx_line == LINE_MARK; endproperty
  a_idle: assert property (p_idle) else $error("idle");
endmodule // sstp_chk
////////////////////////////////////////
bind sstp_port sstp_chk sstp_chk_inst (.clock(clock), .rst_n(rst_n),
  .io_out_strobe(io_out_strobe), .io_code(io_code), .data_bus(data_bus),
  .rx_line(rx_line), .tx_line(tx_line), .reader_run(reader_run),
  .port_select(port_select), .pready(pready),
  .receive_flag_input_low_o(receive_flag_input_low_o),
  .receive_flag_input_low_oe(receive_flag_input_low_oe));
`default_nettype wire

// ===== verif/sstp_term.sv
`timescale 1ns/100ps
`default_nettype none
module sstp_term
(
  input wire logic clock,
  output logic rx_line
);
  // line rests at mark
  initial rx_line = 1'b1;
  // one bit time, change after edge
  task automatic send_bit(input logic b);
    @(posedge clock);
    rx_line <= b;
    repeat (5) @(posedge clock);
  endtask
endmodule // sstp_term
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sstp_pkg::*;
  logic clock, rst_n, psel, penable, pwrite, stb, sel, rdy, err, rx, tx, run, fo, foe;
  logic [7:0] paddr, code, db;
  logic [9:0] f;
  logic [31:0] pwdata, prd, rd;
  logic er;
  int n_mismatch = 0, samples_checked = 0, cyc = 0;
  sstp_port sstp_port_inst (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prd), .pready(rdy),
    .pslverr(err), .io_out_strobe(stb), .io_code(code), .data_bus(db), .rx_line(rx),
    .tx_line(tx), .reader_run(run), .port_select(sel), .receive_flag_input_low_i(foe ? fo : 1'b1),
    .receive_flag_input_low_o(fo), .receive_flag_input_low_oe(foe));
  sstp_term sstp_term_inst (.clock(clock), .rx_line(rx));
  ////////////////////////////////////////
  // 10 MHz, well above the software timing floor
  initial
  begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  task close_out;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      close_out;
    end
  end
  task chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (rdy !== 1'b1);
    rd = prd;
    er = err;
    psel <= 0;
    penable <= 0;
  endtask
  task op(input logic [7:0] c, d);
    @(posedge clock);
    stb <= 1;
    code <= c;
    db <= d;
    @(posedge clock);
    stb <= 0;
    @(negedge clock);
  endtask
  ////////////////////////////////////////
  initial
  begin
    {rst_n, psel, penable, pwrite, stb, paddr, code, db, pwdata} = 0;
    sel = 1;
    repeat (8) @(posedge clock);
    rst_n <= 1;
    @(negedge clock);
    chk(tx, 1);
    // character out, two stop bits, bus bits 1..5 set
    f = {2'b11, 8'h2A};
    op(8'h67, 8'h3E);
    chk(tx, 0);
    for (int i = 0; i < 10; i++)
    begin
      op(8'h67, {7'h1F, f[i]});
      chk(tx, f[i]);
    end
    op(8'h66, 8'h00);
    chk(tx, 1);
    // reader start, hold, stop
    op(8'h67, 8'h81);
    chk(run, 1);
    op(8'h67, 8'h01);
    chk(run, 1);
    op(8'h67, 8'hC1);
    chk(run, 0);
    // received carriage return reaches flag, the calibration character
    f = {1'b1, 8'h0D, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      sstp_term_inst.send_bit(f[i]);
      chk(foe, !f[i]);
      chk(fo, 0);
    end
    // deselected port releases flag
    sel <= 0;
    sstp_term_inst.send_bit(0);
    chk(foe, 0);
    sel <= 1;
    sstp_term_inst.send_bit(1);
    // registers
    apb(0, CTRL_OFFSET, 0);
    chk(rd, CTRL_RESET);
    apb(0, 8'h0C, 0);
    chk(er, 1);
    apb(1, TXCMD_OFFSET, 0);
    @(negedge clock);
    chk(tx, 0);
    close_out;
  end
endmodule // testbench
`default_nettype wire
